// ---- rtl/pdcmr_pkg.sv ----
// pdcmr_pkg: shared constants and types of the control message responder pair
// assumes one 250 MHz clock on both ends, synchronous active-low reset
package pdcmr_pkg;
  // message codes carried on the link
  typedef enum logic [3:0] {
    PDCMR_MSG_NONE = 4'h0,
    PDCMR_MSG_ACCEPT = 4'h1,
    PDCMR_MSG_WAIT = 4'h2,
    PDCMR_MSG_PS_RDY = 4'h3,
    PDCMR_MSG_VCONN_SWAP = 4'h4,
    PDCMR_MSG_NOT_SUPP = 4'h5,
    PDCMR_MSG_SOFT_RESET = 4'h6,
    PDCMR_MSG_REQUEST = 4'h7,
    PDCMR_MSG_PR_SWAP = 4'h8,
    PDCMR_MSG_DR_SWAP = 4'h9,
    PDCMR_MSG_SRC_ALERT = 4'hA,
    PDCMR_MSG_GET_SRC_ST = 4'hB,
    PDCMR_MSG_FR_SWAP = 4'hC,
    PDCMR_MSG_HARD_RESET = 4'hD,
    PDCMR_MSG_GOODCRC = 4'hE,
    PDCMR_MSG_OTHER = 4'hF
  } pdcmr_msg_t;
  // packet start kinds
  typedef enum logic [1:0] {
    PDCMR_SOP = 2'h0,
    PDCMR_SOP_P = 2'h1,
    PDCMR_SOP_PP = 2'h2
  } pdcmr_sop_t;
  // timing, ns figures and derived cycle counts
  localparam int PDCMR_CLK_NS = 4;
  localparam int PDCMR_T_RESP_NS = 15000;      // tReceiverResponse, longest
  localparam int PDCMR_T_VCON_ON_NS = 50000;   // tVCONNSourceOn, longest
  localparam int PDCMR_T_VCOFF_NS = 25000;     // tVCONNSourceOff, longest
  localparam int PDCMR_T_HARD_NS = 5000;       // tHardReset, longest
  localparam int PDCMR_T_FRS_NS = 50;          // tFRSwapInit, least
  localparam int PDCMR_T_CRC_NS = 1000;        // CRC receive timer
  localparam int PDCMR_RESP_CYC = PDCMR_T_RESP_NS / PDCMR_CLK_NS;
  localparam int PDCMR_VCON_ON_CYC = PDCMR_T_VCON_ON_NS / PDCMR_CLK_NS;
  localparam int PDCMR_VCOFF_CYC = PDCMR_T_VCOFF_NS / PDCMR_CLK_NS;
  localparam int PDCMR_HARD_CYC = PDCMR_T_HARD_NS / PDCMR_CLK_NS;
  localparam int PDCMR_FRS_CYC = (PDCMR_T_FRS_NS + PDCMR_CLK_NS - 1) / PDCMR_CLK_NS;
  localparam int PDCMR_CRC_CYC = PDCMR_T_CRC_NS / PDCMR_CLK_NS;
  localparam int PDCMR_N_RETRY = 2;            // nRetryCount
  localparam int PDCMR_TW = 16;                // timer width
  localparam logic [PDCMR_TW-1:0] PDCMR_TMR_RST = 16'h0000;
  localparam logic [1:0] PDCMR_RETRY_RST = 2'h0;
endpackage : pdcmr_pkg

// ---- rtl/pdcmr_link_if.sv ----
// pdcmr_link_if: message link joining the two ends
// assumes both ends share one clock; a message is a one-cycle strobe
`timescale 1ns/1ns
interface pdcmr_link_if;
  import pdcmr_pkg::*;
  logic a_vld;            // message from device end, pulse
  pdcmr_msg_t a_msg;
  pdcmr_sop_t a_sop;
  logic b_vld;            // message from partner end, pulse
  pdcmr_msg_t b_msg;
  pdcmr_sop_t b_sop;
  logic frs_sig;          // fast role swap signal, partner drives, level
  modport dev (output a_vld, output a_msg, output a_sop,
    input b_vld, input b_msg, input b_sop, input frs_sig);
  modport prt (input a_vld, input a_msg, input a_sop,
    output b_vld, output b_msg, output b_sop, output frs_sig);
endinterface : pdcmr_link_if

// ---- rtl/pdcmr_partner.sv ----
// pdcmr_partner: far end, answers vconn and fast swap requests and sends user messages
// assumes the device end is pdcmr_device on the same clock
`timescale 1ns/1ns
module pdcmr_partner
  import pdcmr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  pdcmr_link_if.prt link,
  input wire logic send_req,      // user: send a message
  input wire pdcmr_msg_t send_msg,
  input wire logic frs_req,       // user: raise fast role swap signal
  output logic vconn_on_r,        // partner vconn supplier
  output logic got_accept_r,      // accept seen, pulse
  output logic got_wait_r         // wait seen, pulse
);
  typedef struct packed {
    logic vld;
    pdcmr_msg_t msg;
    logic frs;
    logic vconn;
    logic acc;
    logic wt;
    logic swap_pend;   // our vconn swap sent, waiting for accept
  } pdcmr_prt_st_t;
  pdcmr_prt_st_t st_r, st_nxt;

  // answers and requests, one message per cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.vld = 1'b0;
    st_nxt.msg = PDCMR_MSG_NONE;
    st_nxt.acc = 1'b0;
    st_nxt.wt = 1'b0;
    st_nxt.frs = frs_req;
    if (link.a_vld) begin
      unique case (link.a_msg)
        PDCMR_MSG_VCONN_SWAP, PDCMR_MSG_FR_SWAP: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = PDCMR_MSG_ACCEPT;
        end
        PDCMR_MSG_PS_RDY: begin
          st_nxt.vconn = 1'b0;
        end
        PDCMR_MSG_ACCEPT: begin
          st_nxt.acc = 1'b1;
          if (st_r.swap_pend) begin
            st_nxt.vconn = 1'b1;
            st_nxt.vld = 1'b1;
            st_nxt.msg = PDCMR_MSG_PS_RDY;
            st_nxt.swap_pend = 1'b0;
          end
        end
        PDCMR_MSG_WAIT: begin
          st_nxt.wt = 1'b1;
          st_nxt.swap_pend = 1'b0; // refused swap must not pend on a later accept
        end
        PDCMR_MSG_NOT_SUPP: st_nxt.swap_pend = 1'b0;
        default: ;
      endcase
    end else if (send_req) begin
      st_nxt.vld = 1'b1;
      st_nxt.msg = send_msg;
      if (send_msg == PDCMR_MSG_VCONN_SWAP) begin
        st_nxt.swap_pend = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.b_vld = st_r.vld;
  assign link.b_msg = st_r.msg;
  assign link.b_sop = PDCMR_SOP;
  assign link.frs_sig = st_r.frs;
  assign vconn_on_r = st_r.vconn;
  assign got_accept_r = st_r.acc;
  assign got_wait_r = st_r.wt;
endmodule : pdcmr_partner

// ---- rtl/pdcmr_device.sv ----
// pdcmr_device: documented port end, control message responder
// assumes link messages are one-cycle strobes on the shared clock
// Contract
// - vconn capable port supports vconn swap
// - vconn swap request answered with accept
// - new supplier sends ps_rdy within limit
// - old supplier stops vconn after ps_rdy
// - roles and cc resistors kept during swap
// - vconn make before break
// - become vconn supplier before cable talk
// - not supported lets port take vconn
// - wait answers request or role swaps
// - wait sent within receiver response time
// - request wait only under explicit contract
// - sink request spacing kept by partner
// - failed soft reset escalates to hard reset
// - soft reset keeps power roles
// - soft reset targets packet kind only
// - soft reset cable after vconn swap
// - unsupported messages get not supported
// - source alert triggers status re-read
// - fast swap request sent, accept answer
// - fast swap clears protocol counters
// - host sink ignores sop prime early
// - fast swap flips cc resistors
`timescale 1ns/1ns
module pdcmr_device
  import pdcmr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  pdcmr_link_if.dev link,
  input wire logic vconn_capable,  // port may supply vconn
  input wire logic busy,           // cannot act now, answer wait
  input wire logic contract,       // explicit contract present
  input wire logic is_source,      // present power role
  input wire logic is_dfp,         // present data role
  input wire logic cable_req,      // user wants to talk to cable
  input wire pdcmr_sop_t cable_sop,
  input wire logic sr_fail,        // soft reset got no goodcrc
  input wire logic detach,         // detach seen
  output logic vconn_on_r,         // vconn supplier
  output logic rp_on_r,            // cc pull-up (else pull-down)
  output logic cable_go_r,         // cable talk allowed, pulse
  output logic hard_reset_r,       // start hard reset, pulse
  output logic proto_clr_r,        // clear msg id/retry/caps, pulse
  output logic sop_p_ena_r,        // sop prime reception enabled
  output logic [1:0] sr_target_r   // last soft reset target
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_VC_REQ = 3'b001,    // sent vconn swap, awaiting answer
    S_VC_ON = 3'b011,     // turned on, sending ps_rdy
    S_VC_OFF = 3'b010,    // partner swap accepted, awaiting its ps_rdy to drop vconn
    S_SRST = 3'b110,      // soft reset to cable in flight
    S_FRS = 3'b111,       // fast swap delay then request
    S_FRS_W = 3'b101      // awaiting fast swap accept
  } pdcmr_st_t;
  typedef struct packed {
    pdcmr_st_t st;
    logic vld;
    pdcmr_msg_t msg;
    pdcmr_sop_t sop;
    logic vconn;
    logic rp;
    logic go;
    logic hr;
    logic clr;
    logic sope;
    logic [1:0] tgt;
    logic [1:0] cab_rst;   // per sop' / sop'' reset done since swap
    logic vc_forced;       // allowed to supply after not supported
    logic [1:0] retry;
    logic [PDCMR_TW-1:0] tmr;
    logic frs_s1;
    logic frs_s2;
    logic frs_d;
  } pdcmr_dev_st_t;
  pdcmr_dev_st_t st_r, st_nxt;
  logic [1:0] sop_bit;     // cab_rst index of cable_sop

  // main responder; incoming answers take priority over own requests
  always_comb begin
    st_nxt = st_r;
    sop_bit = (cable_sop == PDCMR_SOP_PP) ? 2'b10 : 2'b01;
    st_nxt.vld = 1'b0;
    st_nxt.msg = PDCMR_MSG_NONE;
    st_nxt.sop = PDCMR_SOP;
    st_nxt.go = 1'b0;
    st_nxt.hr = 1'b0;
    st_nxt.clr = 1'b0;
    st_nxt.frs_s1 = link.frs_sig;
    st_nxt.frs_s2 = st_r.frs_s1;
    st_nxt.frs_d = st_r.frs_s2;
    st_nxt.sope = !(is_dfp && !is_source && !contract);
    if (st_r.tmr != PDCMR_TMR_RST) begin
      st_nxt.tmr = st_r.tmr - 16'h0001;
    end
    if (detach) begin
      st_nxt.vc_forced = 1'b0;
      st_nxt.vconn = st_r.vconn && !st_r.vc_forced; // forced supply ends with attach
      st_nxt.cab_rst = 2'b00;
    end
    // answers to incoming messages, sent next cycle, well inside response time
    if (link.b_vld && !(link.b_sop == PDCMR_SOP_P && !st_r.sope)) begin
      unique case (link.b_msg)
        PDCMR_MSG_VCONN_SWAP: begin
          st_nxt.vld = 1'b1;
          if (!vconn_capable) begin
            st_nxt.msg = PDCMR_MSG_NOT_SUPP;
          end else if (busy) begin
            st_nxt.msg = PDCMR_MSG_WAIT;
          end else begin
            st_nxt.msg = PDCMR_MSG_ACCEPT;
            if (!st_r.vconn) begin
              st_nxt.st = S_VC_ON;
              st_nxt.vconn = 1'b1;
              st_nxt.tmr = 16'(PDCMR_VCON_ON_CYC);
            end else begin
              st_nxt.st = S_VC_OFF;
            end
          end
        end
        PDCMR_MSG_PR_SWAP, PDCMR_MSG_DR_SWAP: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = busy ? PDCMR_MSG_WAIT : PDCMR_MSG_ACCEPT;
        end
        PDCMR_MSG_REQUEST: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = (busy && contract) ? PDCMR_MSG_WAIT : PDCMR_MSG_ACCEPT;
        end
        PDCMR_MSG_PS_RDY: begin
          if (st_r.st == S_VC_OFF) begin
            st_nxt.vconn = 1'b0;
            st_nxt.cab_rst = 2'b00;
            st_nxt.st = S_IDLE;
          end
        end
        PDCMR_MSG_NOT_SUPP: begin
          if (st_r.st == S_VC_REQ) begin
            st_nxt.vc_forced = 1'b1;
            st_nxt.vconn = 1'b1;
            st_nxt.cab_rst = 2'b00;
            st_nxt.st = S_IDLE;
          end
        end
        PDCMR_MSG_ACCEPT: begin
          if (st_r.st == S_VC_REQ) begin
            st_nxt.vconn = 1'b1;
            st_nxt.vld = 1'b1;
            st_nxt.msg = PDCMR_MSG_PS_RDY;
            st_nxt.cab_rst = 2'b00;
            st_nxt.st = S_IDLE;
          end else if (st_r.st == S_FRS_W) begin
            st_nxt.rp = 1'b1;
            st_nxt.clr = 1'b1;
            st_nxt.retry = PDCMR_RETRY_RST;
            st_nxt.st = S_IDLE;
          end
        end
        PDCMR_MSG_FR_SWAP: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = PDCMR_MSG_ACCEPT;
          st_nxt.rp = 1'b0;
          st_nxt.clr = 1'b1;
          st_nxt.retry = PDCMR_RETRY_RST;
        end
        PDCMR_MSG_SRC_ALERT: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = PDCMR_MSG_GET_SRC_ST;
        end
        PDCMR_MSG_SOFT_RESET: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = PDCMR_MSG_ACCEPT;
          st_nxt.clr = 1'b1;
        end
        PDCMR_MSG_WAIT: begin
          if (st_r.st == S_VC_REQ) st_nxt.st = S_IDLE;
        end
        PDCMR_MSG_GOODCRC, PDCMR_MSG_GET_SRC_ST,
        PDCMR_MSG_NONE, PDCMR_MSG_HARD_RESET: ;
        default: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = PDCMR_MSG_NOT_SUPP;
        end
      endcase
    end else begin
      // own sequences; vconn and cc roles untouched by soft reset
      unique case (st_r.st)
        S_IDLE: begin
          if (st_r.frs_d == 1'b0 && st_r.frs_s2 && !is_source) begin
            st_nxt.st = S_FRS;
            st_nxt.tmr = 16'(PDCMR_FRS_CYC);
          end else if (cable_req && !st_r.vconn) begin
            st_nxt.vld = 1'b1;
            st_nxt.msg = PDCMR_MSG_VCONN_SWAP;
            st_nxt.st = S_VC_REQ;
          end else if (cable_req && (st_r.cab_rst & sop_bit) == 2'b00
                       && cable_sop != PDCMR_SOP) begin
            st_nxt.vld = 1'b1;
            st_nxt.msg = PDCMR_MSG_SOFT_RESET;
            st_nxt.sop = cable_sop;
            st_nxt.tgt = cable_sop;
            st_nxt.retry = PDCMR_RETRY_RST;
            st_nxt.tmr = 16'(PDCMR_CRC_CYC);
            st_nxt.st = S_SRST;
          end else if (cable_req) begin
            st_nxt.go = 1'b1;
          end
        end
        S_SRST: begin
          if (!sr_fail) begin
            st_nxt.cab_rst = st_r.cab_rst | sop_bit;
            st_nxt.st = S_IDLE;
          end else if (st_r.tmr == PDCMR_TMR_RST) begin
            if (st_r.retry == 2'(PDCMR_N_RETRY)) begin
              st_nxt.hr = 1'b1;
              st_nxt.vc_forced = 1'b0;
              st_nxt.vconn = st_r.vconn && !st_r.vc_forced;
              st_nxt.st = S_IDLE;
            end else begin
              st_nxt.retry = st_r.retry + 2'h1;
              st_nxt.vld = 1'b1;
              st_nxt.msg = PDCMR_MSG_SOFT_RESET;
              st_nxt.sop = pdcmr_sop_t'(st_r.tgt);
              st_nxt.tmr = 16'(PDCMR_CRC_CYC);
            end
          end
        end
        S_FRS: begin
          if (st_r.tmr == PDCMR_TMR_RST) begin
            st_nxt.vld = 1'b1;
            st_nxt.msg = PDCMR_MSG_FR_SWAP;
            st_nxt.st = S_FRS_W;
          end
        end
        S_VC_ON: begin
          st_nxt.vld = 1'b1;
          st_nxt.msg = PDCMR_MSG_PS_RDY;
          st_nxt.cab_rst = 2'b00;
          st_nxt.st = S_IDLE;
        end
        S_VC_REQ, S_VC_OFF, S_FRS_W: ; // wait for partner, roles held
        default: st_nxt.st = S_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.a_vld = st_r.vld;
  assign link.a_msg = st_r.msg;
  assign link.a_sop = st_r.sop;
  assign vconn_on_r = st_r.vconn;
  assign rp_on_r = st_r.rp;
  assign cable_go_r = st_r.go;
  assign hard_reset_r = st_r.hr;
  assign proto_clr_r = st_r.clr;
  assign sop_p_ena_r = st_r.sope;
  assign sr_target_r = st_r.tgt;
endmodule : pdcmr_device

// ---- bench/pdcmr_properties.sv ----
// pdcmr_properties: link checks of the responder pair
// assumes it sits beside the link, one clock, sync reset
`timescale 1ns/1ns
module pdcmr_properties
  import pdcmr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic a_vld,
  input wire pdcmr_msg_t a_msg,
  input wire pdcmr_sop_t a_sop,
  input wire logic b_vld,
  input wire pdcmr_msg_t b_msg,
  input wire pdcmr_sop_t b_sop,
  input wire logic frs_sig
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // strobe from the partner end
  sequence s_got(pdcmr_msg_t m);
    b_vld && b_msg == m;
  endsequence
  // strobe from the device end
  sequence s_ans(pdcmr_msg_t m);
    a_vld && a_msg == m;
  endsequence
  // answers come exactly one cycle after the request
  vswap_answer_a: assert property (s_got(PDCMR_MSG_VCONN_SWAP) |=> a_vld &&
    a_msg inside {PDCMR_MSG_ACCEPT, PDCMR_MSG_WAIT}) else $error("vconn swap unanswered");
  request_answer_a: assert property (s_got(PDCMR_MSG_REQUEST) |=> a_vld &&
    a_msg inside {PDCMR_MSG_ACCEPT, PDCMR_MSG_WAIT}) else $error("request unanswered");
  frs_accept_a: assert property (s_got(PDCMR_MSG_FR_SWAP) |=>
    s_ans(PDCMR_MSG_ACCEPT)) else $error("fast swap not accepted");
  unknown_reply_a: assert property (s_got(PDCMR_MSG_OTHER) |=>
    s_ans(PDCMR_MSG_NOT_SUPP)) else $error("unknown message not refused");
  alert_reread_a: assert property (s_got(PDCMR_MSG_SRC_ALERT) |=>
    s_ans(PDCMR_MSG_GET_SRC_ST)) else $error("status not re-read");
  // wait only ever answers a request or a swap
  wait_cause_a: assert property (s_ans(PDCMR_MSG_WAIT) |-> $past(b_vld) &&
    $past(b_msg) inside {PDCMR_MSG_REQUEST, PDCMR_MSG_PR_SWAP, PDCMR_MSG_DR_SWAP,
    PDCMR_MSG_VCONN_SWAP}) else $error("wait without cause");
  // own swap accepted, ready follows promptly
  swap_ready_a: assert property (s_ans(PDCMR_MSG_VCONN_SWAP) ##[1:8]
    s_got(PDCMR_MSG_ACCEPT) |=> ##[0:4] s_ans(PDCMR_MSG_PS_RDY)) else $error("no ps_rdy");
  // sync plus init delay: never soon after the signal
  frs_late_a: assert property (s_ans(PDCMR_MSG_FR_SWAP) |-> frs_sig &&
    $past(frs_sig, 12)) else $error("fast swap sent early");
endmodule : pdcmr_properties

// ---- bench/pd_control_message_responder_tb.sv ----
// pd_control_message_responder_tb: both ends joined, user sides driven
// assumes pdcmr_pkg timing figures and one 250 MHz clock
`timescale 1ns/1ns
module pd_control_message_responder_tb;
  import pdcmr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic vconn_capable = 1'b1; // tied: always swap capable
  logic busy = 1'b0;
  logic contract = 1'b0;
  logic is_source = 1'b0;
  logic is_dfp = 1'b0;
  logic cable_req = 1'b0;
  pdcmr_sop_t cable_sop = PDCMR_SOP_P;
  logic sr_fail = 1'b0;
  logic detach = 1'b0; // tied: no detach
  logic send_req = 1'b0;
  pdcmr_msg_t send_msg = PDCMR_MSG_NONE;
  logic frs_req = 1'b0;
  logic dv_von, pt_von, pt_wait, rp_on_r, cable_go_r, hard_reset_r, proto_clr_r;
  logic sop_p_ena_r, rp0;
  logic [1:0] sr_target_r;
  logic mbb = 1'b0; // vconn gap watch armed
  pdcmr_sop_t last_sop; // sop of last device strobe
  int seen[20]; // strobe counts: messages, then go, hard reset, clear, partner wait
  int base[20]; // snapshot taken before a step
  int waited;
  int n;
  int mismatches = 0;
  int check_count = 0;
  pdcmr_link_if link ();
  pdcmr_device i_pdcmr_device (.clock, .rst_n, .link(link.dev), .vconn_capable, .busy,
    .contract, .is_source, .is_dfp, .cable_req, .cable_sop, .sr_fail, .detach,
    .vconn_on_r(dv_von), .rp_on_r, .cable_go_r, .hard_reset_r, .proto_clr_r,
    .sop_p_ena_r, .sr_target_r);
  pdcmr_partner i_pdcmr_partner (.clock, .rst_n, .link(link.prt), .send_req, .send_msg,
    .frs_req, .vconn_on_r(pt_von), .got_accept_r(), .got_wait_r(pt_wait));
  pdcmr_properties i_pdcmr_properties (.clock, .rst_n, .a_vld(link.a_vld),
    .a_msg(link.a_msg), .a_sop(link.a_sop), .b_vld(link.b_vld), .b_msg(link.b_msg),
    .b_sop(link.b_sop), .frs_sig(link.frs_sig));
  // 4 ns clock
  always #2 clock = ~clock;
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check
  // partner user side sends one message, device answer one cycle after
  task automatic ask(input pdcmr_msg_t m, input pdcmr_msg_t e);
    send_msg = m;
    send_req = 1'b1;
    n = 0;
    // held until put out: the partner drops it in a cycle with an incoming strobe
    do begin
      cyc(1);
      n++;
    end while (!(link.b_vld === 1'b1 && link.b_msg === m) && n < 8);
    send_req = 1'b0;
    cyc(1);
    check(link.a_msg & {4{link.a_vld}}, e, "answer");
  endtask : ask
  // bounded wait for the next strobe of kind k after the snapshot
  task automatic wait_ev(input int k, input int lim, input string what);
    waited = 0;
    while (seen[k] == base[k] && waited < lim) begin
      cyc(1);
      waited++;
    end
    check(seen[k] != base[k], 1'b1, what);
  endtask : wait_ev
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // strobe counting, sampled before the edge updates land
  always @(posedge clock) begin
    if (link.a_vld === 1'b1) begin
      seen[link.a_msg]++;
      last_sop = link.a_sop;
    end
    if (cable_go_r === 1'b1) seen[16]++;
    if (hard_reset_r === 1'b1) seen[17]++;
    if (proto_clr_r === 1'b1) seen[18]++;
    if (pt_wait === 1'b1) seen[19]++;
    if (mbb && dv_von !== 1'b1 && pt_von !== 1'b1) check(4'h0, 4'h1, "vconn gap");
  end
  // hang guard, flow needs about 800 cycles
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    // cable talk: take vconn, reset the plug, then go
    base = seen;
    cable_req = 1'b1;
    wait_ev(PDCMR_MSG_VCONN_SWAP, 50, "swap asked");
    wait_ev(PDCMR_MSG_PS_RDY, 50, "ps_rdy");
    cyc(1);
    mbb = 1'b1;
    wait_ev(PDCMR_MSG_SOFT_RESET, 50, "plug reset");
    check(last_sop, PDCMR_SOP_P, "reset sop");
    wait_ev(16, 50, "cable go");
    cable_req = 1'b0;
    check(sr_target_r, PDCMR_SOP_P, "reset target");
    // busy with contract waits, otherwise accepts
    // requests spaced by whole answer turns, never back to back
    for (int i = 0; i < 3; i++) begin
      busy = (i != 2);
      contract = (i != 1);
      ask(PDCMR_MSG_REQUEST, (i == 0) ? PDCMR_MSG_WAIT : PDCMR_MSG_ACCEPT);
    end
    check(4'(seen[19] - base[19]), 4'h1, "partner saw wait");
    ask(PDCMR_MSG_OTHER, PDCMR_MSG_NOT_SUPP);
    ask(PDCMR_MSG_SRC_ALERT, PDCMR_MSG_GET_SRC_ST);
    // partner takes vconn, make before break
    rp0 = rp_on_r;
    ask(PDCMR_MSG_VCONN_SWAP, PDCMR_MSG_ACCEPT);
    n = 0;
    while (!(link.b_vld === 1'b1 && link.b_msg === PDCMR_MSG_PS_RDY) && n < 13000) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (dv_von === 1'b1 && n < 7000) begin
      cyc(1);
      n++;
    end
    check(n <= PDCMR_VCOFF_CYC, 1'b1, "vconn release");
    check({pt_von, dv_von, rp_on_r}, {2'b10, rp0}, "roles kept");
    // fast swap as new source, then as new sink
    base = seen;
    frs_req = 1'b1;
    wait_ev(PDCMR_MSG_FR_SWAP, 100, "fast swap");
    check(waited >= PDCMR_FRS_CYC, 1'b1, "fast swap early");
    wait_ev(18, 20, "counters cleared");
    check({rp_on_r, dv_von}, 2'b10, "new source pull-up");
    frs_req = 1'b0;
    is_source = 1'b1;
    base = seen;
    ask(PDCMR_MSG_FR_SWAP, PDCMR_MSG_ACCEPT);
    cyc(2);
    check({rp_on_r, dv_von}, 2'b00, "new sink pull-down");
    check(seen[18] != base[18], 1'b1, "sink clear");
    // host sink keeps sop prime shut until a contract
    is_source = 1'b0;
    is_dfp = 1'b1;
    contract = 1'b0;
    cyc(3);
    check(sop_p_ena_r, 1'b0, "sop prime shut");
    contract = 1'b1;
    cyc(3);
    check(sop_p_ena_r, 1'b1, "sop prime open");
    // unanswered plug reset escalates after retries
    mbb = 1'b0;
    sr_fail = 1'b1;
    cable_sop = PDCMR_SOP_PP;
    base = seen;
    cable_req = 1'b1;
    wait_ev(17, 3000, "hard reset");
    cable_req = 1'b0;
    n = seen[PDCMR_MSG_SOFT_RESET] - base[PDCMR_MSG_SOFT_RESET];
    check(4'(n), 4'(1 + PDCMR_N_RETRY), "retries");
    give_verdict();
  end
endmodule : pd_control_message_responder_tb
